/* File: rtl/oscdc_top.sv */
// oscillator select and divider control: registers, switch sequencing, clock rate outputs
`timescale 1ns/1ns
`default_nettype none
module oscdc_top
   import oscdc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire oscdc_cfg_t cfg,
   input wire oscdc_bus_t bus,
   output logic [15:0] rdata,
   input wire logic pin_map_unlock,
   input wire logic [7:0] src_ready,
   input wire logic pll_locked,
   input wire logic clock_failure,
   input wire logic interrupt_event,
   input wire logic sleep_mode,
   output logic [2:0] sys_source,
   output logic pll_on,
   output logic primary_osc_run,
   output logic secondary_osc_run,
   output logic failsafe_clock_monitor,
   output logic pin_map_lock,
   output oscdc_clk_t clk_div
);
   typedef struct packed {
      logic [2:0] cur_src;
      logic [2:0] nxt_src;
      logic swreq;
      logic sel_lock;
      logic pm_lock;
      logic lock;
      logic cf;
      logic pslp;
      logic secondary_oscillator_en;
      logic recover_on_interrupt;
      logic [2:0] doze;
      logic doze_enable;
      logic [2:0] rc_postscaler_field;
      logic [1:0] pll_branch_postscaler;
      logic pll_enable;
      logic [7:0] pll_cnt;
      oscdc_sw_t sw;
      logic strap_done;
      logic [15:0] rdata;
   } oscdc_state_t;

   oscdc_state_t s_reg, s_next;
   logic switch_allowed;
   logic locked_sel;
   logic sw_stable;
   logic sw_start;
   logic [15:0] ctrl_word;
   logic [15:0] div_word;
   logic pll_in_use;
   logic ctrl_wr_hit;
   logic div_wr_hit;

   function automatic logic src_uses_pll(input logic [2:0] src);
      return (src == OSCDC_SRC_FAST_RC_WITH_PLL_MODE) || (src == OSCDC_SRC_PRIPLL);
   endfunction

   function automatic logic [8:0] pow2(input logic [2:0] code);
      return 9'h001 << code;
   endfunction

   assign switch_allowed = !cfg.switch_monitor_config[1];
   assign failsafe_clock_monitor = (cfg.switch_monitor_config == 2'b00);
   // lock only bites while the monitor configuration permits it
   assign locked_sel = s_reg.sel_lock && failsafe_clock_monitor;
   assign sw_start = (s_reg.sw == OSCDC_SW_IDLE) && s_reg.swreq && s_reg.strap_done
      && (s_reg.nxt_src != OSCDC_SRC_RSVD);
   // the pll only counts as running when enabled and the active source routes through it
   assign pll_in_use = s_reg.pll_enable && src_uses_pll(s_reg.cur_src);
   assign ctrl_wr_hit = bus.wr && (bus.addr == OSCDC_ADDR_CTRL);
   assign div_wr_hit = bus.wr && (bus.addr == OSCDC_ADDR_DIV);

   oscdc_stable_wait u_wait (
      .clk(clk),
      .resetn(resetn),
      .start(sw_start),
      .src_ready(src_ready[s_reg.nxt_src]),
      .stable(sw_stable)
   );

   always_comb begin
      ctrl_word = '0;
      ctrl_word[OSCDC_B_CURRENT_SOURCE_FIELD +: 3] = s_reg.cur_src;
      ctrl_word[OSCDC_B_NEXT_SOURCE_FIELD +: 3] = s_reg.nxt_src;
      ctrl_word[OSCDC_B_SLOCK] = s_reg.sel_lock;
      ctrl_word[OSCDC_B_PLOCK] = s_reg.pm_lock;
      ctrl_word[OSCDC_B_LOCK] = s_reg.lock;
      ctrl_word[OSCDC_B_CF] = s_reg.cf;
      ctrl_word[OSCDC_B_PSLP] = s_reg.pslp;
      ctrl_word[OSCDC_B_SECONDARY_OSCILLATOR] = s_reg.secondary_oscillator_en;
      ctrl_word[OSCDC_B_SWREQ] = s_reg.swreq;
      div_word = '0;
      div_word[OSCDC_B_ROI] = s_reg.recover_on_interrupt;
      div_word[OSCDC_B_DOZE +: 3] = s_reg.doze;
      div_word[OSCDC_B_DOZE_ENABLE] = s_reg.doze_enable;
      div_word[OSCDC_B_RC_POSTSCALER_FIELD +: 3] = s_reg.rc_postscaler_field;
      div_word[OSCDC_B_PLL_BRANCH_POSTSCALER +: 2] = s_reg.pll_branch_postscaler;
      div_word[OSCDC_B_PLL_ENABLE] = s_reg.pll_enable;
   end

   always_comb begin
      logic wr_ctrl;
      logic wr_div;
      logic pll_active;
      wr_ctrl = bus.wr && (bus.addr == OSCDC_ADDR_CTRL);
      wr_div = bus.wr && (bus.addr == OSCDC_ADDR_DIV);
      pll_active = 1'b0;
      s_next = s_reg;
      // configuration straps are taken on the first clock after reset release
      if (!s_reg.strap_done) begin
         s_next.strap_done = 1'b1;
         s_next.cur_src = cfg.initial_source_config;
         s_next.nxt_src = cfg.initial_source_config;
      end
      s_next.rdata = '0;
      if (bus.rd) begin
         case (bus.addr)
            OSCDC_ADDR_CTRL: s_next.rdata = ctrl_word;
            OSCDC_ADDR_DIV: s_next.rdata = div_word;
            default: s_next.rdata = '0;
         endcase
      end
      if (wr_ctrl) begin
         if (!locked_sel) begin
            s_next.nxt_src = bus.wdata[OSCDC_B_NEXT_SOURCE_FIELD +: 3];
            if (bus.wdata[OSCDC_B_SWREQ] && switch_allowed) begin
               s_next.swreq = 1'b1;
            end
         end
         if (bus.wdata[OSCDC_B_SLOCK]) begin
            s_next.sel_lock = 1'b1;
         end
         if (pin_map_unlock && !(s_reg.pm_lock && cfg.pin_map_one_way_config)) begin
            s_next.pm_lock = bus.wdata[OSCDC_B_PLOCK];
         end
         if (!bus.wdata[OSCDC_B_CF]) begin
            s_next.cf = 1'b0;
         end
         s_next.pslp = bus.wdata[OSCDC_B_PSLP];
         s_next.secondary_oscillator_en = bus.wdata[OSCDC_B_SECONDARY_OSCILLATOR];
      end
      if (wr_div) begin
         s_next.recover_on_interrupt = bus.wdata[OSCDC_B_ROI];
         s_next.doze = bus.wdata[OSCDC_B_DOZE +: 3];
         s_next.doze_enable = bus.wdata[OSCDC_B_DOZE_ENABLE];
         s_next.rc_postscaler_field = bus.wdata[OSCDC_B_RC_POSTSCALER_FIELD +: 3];
         // software keeps pll_branch_postscaler low while usb runs; hardware takes it as written
         s_next.pll_branch_postscaler = bus.wdata[OSCDC_B_PLL_BRANCH_POSTSCALER +: 2];
         if (!locked_sel) begin
            s_next.pll_enable = bus.wdata[OSCDC_B_PLL_ENABLE];
         end
      end
      // interrupt recovery wins over a same-cycle write of doze enable
      if (s_reg.recover_on_interrupt && interrupt_event) begin
         s_next.doze_enable = 1'b0;
      end
      if (failsafe_clock_monitor && clock_failure) begin
         s_next.cf = 1'b1;
      end
      // a reserved target simply drops the request
      if (s_reg.sw == OSCDC_SW_IDLE && s_reg.swreq && s_reg.nxt_src == OSCDC_SRC_RSVD) begin
         s_next.swreq = 1'b0;
      end
      case (s_reg.sw)
         OSCDC_SW_IDLE: begin
            if (sw_start) begin
               s_next.sw = OSCDC_SW_WAIT;
            end
         end
         OSCDC_SW_WAIT: begin
            if (sw_stable) begin
               s_next.cur_src = s_reg.nxt_src;
               s_next.sw = OSCDC_SW_DONE;
            end
         end
         OSCDC_SW_DONE: begin
            s_next.swreq = 1'b0;
            s_next.sw = OSCDC_SW_IDLE;
         end
         default: s_next.sw = OSCDC_SW_IDLE;
      endcase
      pll_active = pll_in_use;
      if (!pll_active || sw_start || s_reg.sw != OSCDC_SW_IDLE) begin
         s_next.lock = 1'b0;
         s_next.pll_cnt = OSCDC_PLL_START_CNT;
      end else if (s_reg.pll_cnt != 8'h00) begin
         s_next.pll_cnt = s_reg.pll_cnt - 8'h01;
         s_next.lock = pll_locked;
      end else begin
         s_next.lock = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
         s_reg.cur_src <= OSCDC_SRC_DIVIDED_FAST_RC_MODE;
         s_reg.nxt_src <= OSCDC_SRC_DIVIDED_FAST_RC_MODE;
         s_reg.rc_postscaler_field <= OSCDC_RC_POSTSCALER_FIELD_RST;
         s_reg.sw <= OSCDC_SW_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata = s_reg.rdata;
   assign sys_source = s_reg.cur_src;
   assign pll_on = s_reg.pll_enable;
   assign primary_osc_run = !sleep_mode || s_reg.pslp;
   assign secondary_osc_run = s_reg.secondary_oscillator_en;
   assign pin_map_lock = s_reg.pm_lock;

   // division ratios seen by the clock generator; instruction clock halves the primary path
   always_comb begin
      clk_div.pri_div = 9'h002;
      clk_div.rc_div = (s_reg.rc_postscaler_field == 3'h7) ? 9'h100 : pow2(s_reg.rc_postscaler_field);
      clk_div.pll_div = 4'h1 << s_reg.pll_branch_postscaler;
      clk_div.doze_div = s_reg.doze_enable ? 8'(pow2(s_reg.doze)) : 8'h01;
   end

   chk_switch_gate: assert property (@(posedge clk) disable iff (!resetn)
      cfg.switch_monitor_config[1] |-> s_reg.sw != OSCDC_SW_WAIT || $past(s_reg.sw) != OSCDC_SW_IDLE)
      else $error("switch started while switching disabled");
   chk_lock_sticky: assert property (@(posedge clk) disable iff (!resetn)
      s_reg.sel_lock |=> s_reg.sel_lock)
      else $error("selection lock cleared");
   chk_cf_sticky: assert property (@(posedge clk) disable iff (!resetn)
      (failsafe_clock_monitor && clock_failure) |=> s_reg.cf)
      else $error("clock fail not flagged");
   chk_pll_nonpll: assert property (@(posedge clk) disable iff (!resetn)
      !pll_in_use |=> !s_reg.lock)
      else $error("pll lock high without pll");
   chk_roi_doze: assert property (@(posedge clk) disable iff (!resetn)
      (s_reg.recover_on_interrupt && interrupt_event) |=> !s_reg.doze_enable)
      else $error("doze not cleared by interrupt");
   chk_doze_ratio: assert property (@(posedge clk) disable iff (!resetn)
      !s_reg.doze_enable |-> clk_div.doze_div == 8'h01)
      else $error("doze ratio not 1:1");
   chk_rsvd_target: assert property (@(posedge clk) disable iff (!resetn)
      (s_reg.swreq && s_reg.sw == OSCDC_SW_IDLE && s_reg.nxt_src == OSCDC_SRC_RSVD)
      |=> $stable(s_reg.cur_src) && !s_reg.swreq)
      else $error("reserved target changed source");
   chk_pinmap_oneway: assert property (@(posedge clk) disable iff (!resetn)
      (s_reg.pm_lock && cfg.pin_map_one_way_config) |=> s_reg.pm_lock)
      else $error("pin map lock cleared in one-way mode");
   chk_swreq_clear: assert property (@(posedge clk) disable iff (!resetn)
      (s_reg.sw == OSCDC_SW_DONE) |=> !s_reg.swreq && s_reg.sw == OSCDC_SW_IDLE)
      else $error("switch request not cleared");

   // switch sequencing: launch, settle, retire
   sequence seq_sw_launch;
      s_reg.sw == OSCDC_SW_IDLE && sw_start;
   endsequence
   sequence seq_sw_settled;
      s_reg.sw == OSCDC_SW_WAIT && sw_stable;
   endsequence
   sequence seq_sw_retire;
      s_reg.sw == OSCDC_SW_DONE ##1 (s_reg.sw == OSCDC_SW_IDLE && !s_reg.swreq);
   endsequence

   chk_switch_launch: assert property (@(posedge clk) disable iff (!resetn)
      seq_sw_launch |=> s_reg.sw == OSCDC_SW_WAIT && !s_reg.lock)
      else $error("switch did not start");
   chk_switch_target: assert property (@(posedge clk) disable iff (!resetn)
      seq_sw_settled |=> s_reg.cur_src == $past(s_reg.nxt_src))
      else $error("current source is not the switch target");
   chk_switch_retire: assert property (@(posedge clk) disable iff (!resetn)
      seq_sw_settled |=> seq_sw_retire)
      else $error("switch did not retire");
   chk_cur_hold: assert property (@(posedge clk) disable iff (!resetn)
      (s_reg.strap_done && !(s_reg.sw == OSCDC_SW_WAIT && sw_stable))
      |=> $stable(s_reg.cur_src))
      else $error("current source moved outside a settled switch");
   chk_strap_load: assert property (@(posedge clk) disable iff (!resetn)
      $rose(s_reg.strap_done) |-> s_reg.cur_src == cfg.initial_source_config)
      else $error("start source not taken from configuration");

   // pll lock status: held low through a switch, follows the pll while the timer runs
   chk_lock_switch: assert property (@(posedge clk) disable iff (!resetn)
      (s_reg.sw != OSCDC_SW_IDLE || sw_start) |=> !s_reg.lock)
      else $error("pll lock high during a switch");
   chk_lock_follow: assert property (@(posedge clk) disable iff (!resetn)
      (pll_in_use && s_reg.sw == OSCDC_SW_IDLE && !sw_start && s_reg.pll_cnt != 8'h00)
      |=> s_reg.lock == $past(pll_locked))
      else $error("pll lock does not follow the pll while timing");
   chk_lock_timer: assert property (@(posedge clk) disable iff (!resetn)
      (pll_in_use && s_reg.sw == OSCDC_SW_IDLE && !sw_start && s_reg.pll_cnt == 8'h00)
      |=> s_reg.lock)
      else $error("pll lock low after start-up timer");

   // software writes and their guards
   chk_nxt_write: assert property (@(posedge clk) disable iff (!resetn)
      (ctrl_wr_hit && !locked_sel && s_reg.strap_done)
      |=> s_reg.nxt_src == $past(bus.wdata[OSCDC_B_NEXT_SOURCE_FIELD +: 3]))
      else $error("next source not written");
   chk_lock_freeze: assert property (@(posedge clk) disable iff (!resetn)
      locked_sel |=> $stable(s_reg.nxt_src) && $stable(s_reg.pll_enable))
      else $error("locked selection changed");
   chk_swreq_blocked: assert property (@(posedge clk) disable iff (!resetn)
      (cfg.switch_monitor_config[1] && !s_reg.swreq) |=> !s_reg.swreq)
      else $error("switch request taken while switching disabled");
   chk_unlock_free: assert property (@(posedge clk) disable iff (!resetn)
      (ctrl_wr_hit && bus.wdata[OSCDC_B_SWREQ] && !failsafe_clock_monitor && switch_allowed
      && s_reg.sw == OSCDC_SW_IDLE && !s_reg.swreq) |=> s_reg.swreq)
      else $error("switch request refused with monitor disabled");
   chk_pinmap_guard: assert property (@(posedge clk) disable iff (!resetn)
      !pin_map_unlock |=> $stable(s_reg.pm_lock))
      else $error("pin map lock changed without unlock");
   chk_cf_clear: assert property (@(posedge clk) disable iff (!resetn)
      (ctrl_wr_hit && !bus.wdata[OSCDC_B_CF] && !(failsafe_clock_monitor && clock_failure))
      |=> !s_reg.cf)
      else $error("clock fail not cleared by software");
   chk_cf_monitor_off: assert property (@(posedge clk) disable iff (!resetn)
      (!failsafe_clock_monitor && !s_reg.cf) |=> !s_reg.cf)
      else $error("clock fail set with monitor disabled");
   chk_sleep_primary: assert property (@(posedge clk) disable iff (!resetn)
      sleep_mode ? (primary_osc_run == s_reg.pslp) : primary_osc_run)
      else $error("primary oscillator run state wrong");
   chk_secondary_oscillator_write: assert property (@(posedge clk) disable iff (!resetn)
      ctrl_wr_hit |=> secondary_osc_run == $past(bus.wdata[OSCDC_B_SECONDARY_OSCILLATOR]))
      else $error("secondary oscillator enable not written");
   chk_roi_keep: assert property (@(posedge clk) disable iff (!resetn)
      (!s_reg.recover_on_interrupt && !div_wr_hit) |=> $stable(s_reg.doze_enable))
      else $error("doze enable changed without write");
   chk_pll_write: assert property (@(posedge clk) disable iff (!resetn)
      (div_wr_hit && !locked_sel) |=> pll_on == $past(bus.wdata[OSCDC_B_PLL_ENABLE]))
      else $error("pll enable not written");

   // clock rate outputs
   chk_doze_onehot: assert property (@(posedge clk) disable iff (!resetn)
      s_reg.doze_enable |-> $onehot(clk_div.doze_div) && clk_div.doze_div[s_reg.doze])
      else $error("doze ratio wrong");
   chk_rc_div: assert property (@(posedge clk) disable iff (!resetn)
      $onehot(clk_div.rc_div)
      && (s_reg.rc_postscaler_field == 3'h7 ? clk_div.rc_div[8] : clk_div.rc_div[s_reg.rc_postscaler_field]))
      else $error("rc postscaler ratio wrong");
   chk_pll_div: assert property (@(posedge clk) disable iff (!resetn)
      $onehot(clk_div.pll_div) && clk_div.pll_div[s_reg.pll_branch_postscaler])
      else $error("pll branch ratio wrong");
   chk_pri_half: assert property (@(posedge clk) disable iff (!resetn)
      clk_div.pri_div == 9'h002)
      else $error("instruction clock ratio wrong");
endmodule
`default_nettype wire

/* File: inc/oscdc_pkg.sv */
// package for the oscillator select and divider control block
// Operation
// - switch requests act only when upper switch/monitor config bit is zero
// - fail-safe monitor active only when both switch/monitor bits are zero
// - source codes: 111 div rc, 110 reserved, 101 low_power_internal_rc, 100 secondary_oscillator, 011/010 primary, 001/000 rc
// - current-source field reads active source; next-source resets to initial config
// - unprogrammed device starts on divided fast rc, code 111
// - code 011 is primary with pll, 010 primary; submode from primary mode config (primary_mode_config is not used by this block)
// - writing one to switch request starts switch; hardware clears it when done
// - selection lock freezes source and pll choices; software may only set it
// - with monitor disabled, selections are never locked
// - pin map lock changes only after unlock; one-way config keeps it set
// - pll lock reads one when locked or start-up timer expired, else zero
// - pll lock forced to zero on a valid switch or a non-pll mode
// - clock-fail flag set by monitor detection; software clears only; resets zero
// - primary sleep enable keeps primary oscillator running in sleep
// - secondary oscillator enable turns the 32 kHz oscillator on or off
// - recover on interrupt makes any interrupt clear doze enable
// - doze ratio field selects cpu to peripheral ratio 1:2^code
// - doze enable off forces ratio 1:1
// - rc postscaler divides 8 MHz by 1..64 or 256; reset code 001
// - pll branch postscaler divides 32 MHz by 1, 2, 4 or 8
// - pll enable turns pll on; resets to zero
// - instruction clock is processor clock divided by two; rc nominal 8 MHz
package oscdc_pkg;
   localparam logic [1:0] OSCDC_ADDR_CTRL = 2'h0;
   localparam logic [1:0] OSCDC_ADDR_DIV = 2'h1;
   localparam logic [2:0] OSCDC_SRC_FRC = 3'h0;
   localparam logic [2:0] OSCDC_SRC_FAST_RC_WITH_PLL_MODE = 3'h1;
   localparam logic [2:0] OSCDC_SRC_PRI = 3'h2;
   localparam logic [2:0] OSCDC_SRC_PRIPLL = 3'h3;
   localparam logic [2:0] OSCDC_SRC_SECONDARY_OSCILLATOR = 3'h4;
   localparam logic [2:0] OSCDC_SRC_LOW_POWER_INTERNAL_RC = 3'h5;
   localparam logic [2:0] OSCDC_SRC_RSVD = 3'h6;
   localparam logic [2:0] OSCDC_SRC_DIVIDED_FAST_RC_MODE = 3'h7;
   localparam logic [1:0] OSCDC_PMODE_EC = 2'h0;
   localparam logic [1:0] OSCDC_PMODE_XT = 2'h1;
   localparam logic [1:0] OSCDC_PMODE_HS = 2'h2;
   localparam logic [1:0] OSCDC_PMODE_OFF = 2'h3;
   localparam logic [2:0] OSCDC_RC_POSTSCALER_FIELD_RST = 3'h1;
   localparam int OSCDC_CLK_HZ = 20000000;
   localparam int OSCDC_PLL_START_US = 2;
   localparam int OSCDC_PLL_START_CYC = (OSCDC_CLK_HZ / 1000000) * OSCDC_PLL_START_US;
   localparam logic [7:0] OSCDC_PLL_START_CNT = OSCDC_PLL_START_CYC[7:0];
   localparam logic [3:0] OSCDC_SW_SETTLE_CNT = 4'h8;
   // ctrl word bit positions
   localparam int OSCDC_B_CURRENT_SOURCE_FIELD = 12;
   localparam int OSCDC_B_NEXT_SOURCE_FIELD = 8;
   localparam int OSCDC_B_SLOCK = 7;
   localparam int OSCDC_B_PLOCK = 6;
   localparam int OSCDC_B_LOCK = 5;
   localparam int OSCDC_B_CF = 3;
   localparam int OSCDC_B_PSLP = 2;
   localparam int OSCDC_B_SECONDARY_OSCILLATOR = 1;
   localparam int OSCDC_B_SWREQ = 0;
   // divider word bit positions
   localparam int OSCDC_B_ROI = 15;
   localparam int OSCDC_B_DOZE = 12;
   localparam int OSCDC_B_DOZE_ENABLE = 11;
   localparam int OSCDC_B_RC_POSTSCALER_FIELD = 8;
   localparam int OSCDC_B_PLL_BRANCH_POSTSCALER = 6;
   localparam int OSCDC_B_PLL_ENABLE = 5;
   typedef enum logic [1:0] {
      OSCDC_SW_IDLE = 2'b00,
      OSCDC_SW_WAIT = 2'b01,
      OSCDC_SW_DONE = 2'b10
   } oscdc_sw_t;
   typedef struct packed {
      logic [1:0] switch_monitor_config;
      logic [1:0] primary_mode_config;
      logic [2:0] initial_source_config;
      logic pin_map_one_way_config;
   } oscdc_cfg_t;
   typedef struct packed {
      logic [1:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } oscdc_bus_t;
   typedef struct packed {
      logic [8:0] pri_div;
      logic [8:0] rc_div;
      logic [3:0] pll_div;
      logic [7:0] doze_div;
   } oscdc_clk_t;
endpackage

/* File: rtl/oscdc_stable_wait.sv */
// settle counter that reports when a newly selected source is stable
`timescale 1ns/1ns
`default_nettype none
module oscdc_stable_wait
   import oscdc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic src_ready,
   output logic stable
);
   typedef struct packed {
      logic [3:0] cnt;
      logic run;
      logic stable;
   } oscdc_sw_state_t;
   oscdc_sw_state_t st_reg, st_next;
   always_comb begin
      st_next = st_reg;
      st_next.stable = 1'b0;
      if (start) begin
         st_next.run = 1'b1;
         st_next.cnt = OSCDC_SW_SETTLE_CNT;
      end else if (st_reg.run) begin
         // count only while the source reports running; a dropout restarts the wait
         if (!src_ready) begin
            st_next.cnt = OSCDC_SW_SETTLE_CNT;
         end else if (st_reg.cnt == 4'h1) begin
            st_next.run = 1'b0;
            st_next.stable = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt - 4'h1;
         end
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign stable = st_reg.stable;
endmodule
`default_nettype wire

/* File: testbench/oscdc_top_test.sv */
// self-checking testbench for the oscillator select and divider control block
`timescale 1ns/1ns
`default_nettype none
module oscillator_select_and_divider_control_test;
   import oscdc_pkg::*;
   logic clk;
   logic resetn;
   oscdc_cfg_t cfg;
   oscdc_bus_t bus;
   logic [15:0] rdata;
   logic pin_map_unlock;
   logic [7:0] src_ready;
   logic pll_locked;
   logic clock_failure;
   logic interrupt_event;
   logic sleep_mode;
   logic [2:0] sys_source;
   logic pll_on;
   logic primary_osc_run;
   logic secondary_osc_run;
   logic failsafe_clock_monitor;
   logic pin_map_lock;
   oscdc_clk_t clk_div;
   int fails;
   int tests_run;
   logic [15:0] wd;
   logic [8:0] rcx [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100};

   oscdc_top dut_u (.clk(clk), .resetn(resetn), .cfg(cfg), .bus(bus), .rdata(rdata),
      .pin_map_unlock(pin_map_unlock), .src_ready(src_ready), .pll_locked(pll_locked),
      .clock_failure(clock_failure), .interrupt_event(interrupt_event),
      .sleep_mode(sleep_mode), .sys_source(sys_source), .pll_on(pll_on),
      .primary_osc_run(primary_osc_run), .secondary_osc_run(secondary_osc_run),
      .failsafe_clock_monitor(failsafe_clock_monitor), .pin_map_lock(pin_map_lock),
      .clk_div(clk_div));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   function automatic logic [15:0] cw(input logic [2:0] n, input logic [7:0] lo);
      return {5'h00, n, lo};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rchk(input logic [1:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   // a switch that never completes is counted once, not hung on
   task automatic wait_sw();
      logic [15:0] d;
      d = 16'h0001;
      for (int i = 0; i < 40 && d[0] !== 1'b0; i++) rd(OSCDC_ADDR_CTRL, d);
      chk(d[0], 1'b0);
   endtask

   task automatic rst(input oscdc_cfg_t c);
      @(posedge clk);
      resetn <= 1'b0;
      cfg <= c;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      cyc(2);
   endtask

   task automatic pulse_in(input int which);
      @(posedge clk);
      if (which == 0) clock_failure <= 1'b1;
      else interrupt_event <= 1'b1;
      @(posedge clk);
      clock_failure <= 1'b0;
      interrupt_event <= 1'b0;
      cyc(1);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      finish_test();
   end

   initial begin
      fails = 0;
      tests_run = 0;
      resetn = 1'b0;
      cfg = '{2'b00, 2'b11, 3'b111, 1'b1};
      bus = '0;
      pin_map_unlock = 1'b0;
      src_ready = 8'h00;
      pll_locked = 1'b0;
      clock_failure = 1'b0;
      interrupt_event = 1'b0;
      sleep_mode = 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      cyc(2);
      rchk(OSCDC_ADDR_CTRL, 16'h7700);
      rchk(OSCDC_ADDR_DIV, 16'h0100);
      chk(sys_source, 3'b111);
      chk(failsafe_clock_monitor, 1'b1);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         wd = {1'b0, 3'(i), 1'b1, 3'(i), 2'(i), 6'h00};
         wr(OSCDC_ADDR_DIV, wd); // usb is off here, so pll_branch_postscaler 10 and 11 are allowed
         rchk(OSCDC_ADDR_DIV, wd);
         chk(clk_div.rc_div, rcx[i]);
         chk(clk_div.doze_div, 8'h01 << i);
         chk(clk_div.pll_div, 4'h1 << i[1:0]);
         chk(clk_div.pri_div, 9'h002);
      end
      wr(OSCDC_ADDR_DIV, 16'h5100);
      chk(clk_div.doze_div, 8'h01);
      wr(OSCDC_ADDR_DIV, 16'hB900);
      pulse_in(1);
      rchk(OSCDC_ADDR_DIV, 16'hB100);
      chk(clk_div.doze_div, 8'h01);
      wr(OSCDC_ADDR_DIV, 16'h3900);
      pulse_in(1);
      rchk(OSCDC_ADDR_DIV, 16'h3900);
      chk(clk_div.doze_div, 8'h08);
      rchk(2'h2, 16'h0000);
      wr(2'h3, 16'hFFFF);
      rchk(OSCDC_ADDR_DIV, 16'h3900);
      $display("test divider register done");
      wr(OSCDC_ADDR_CTRL, cw(3'b100, 8'h01));
      cyc(20);
      chk(sys_source, 3'b111);
      rchk(OSCDC_ADDR_CTRL, 16'h7401);
      src_ready <= 8'hFF;
      wait_sw();
      chk(sys_source, 3'b100);
      rchk(OSCDC_ADDR_CTRL, 16'h4400);
      wr(OSCDC_ADDR_CTRL, cw(3'b110, 8'h01));
      cyc(20);
      chk(sys_source, 3'b100);
      wr(OSCDC_ADDR_DIV, 16'h0120);
      chk(pll_on, 1'b1);
      wr(OSCDC_ADDR_CTRL, cw(3'b001, 8'h01));
      wait_sw();
      cyc(60);
      rchk(OSCDC_ADDR_CTRL, 16'h1120);
      wr(OSCDC_ADDR_DIV, 16'h0100);
      chk(pll_on, 1'b0);
      rchk(OSCDC_ADDR_CTRL, 16'h1100);
      pll_locked <= 1'b1;
      wr(OSCDC_ADDR_DIV, 16'h0120);
      cyc(3);
      rchk(OSCDC_ADDR_CTRL, 16'h1120);
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'h01));
      rchk(OSCDC_ADDR_CTRL, 16'h1001);
      wait_sw();
      rchk(OSCDC_ADDR_CTRL, 16'h0000);
      $display("test clock switch done");
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'h06));
      sleep_mode <= 1'b1;
      cyc(2);
      chk(secondary_osc_run, 1'b1);
      chk(primary_osc_run, 1'b1);
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'h02));
      chk(primary_osc_run, 1'b0);
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'h00));
      cyc(1);
      chk(secondary_osc_run, 1'b0);
      sleep_mode <= 1'b0;
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'h40));
      chk(pin_map_lock, 1'b0);
      pin_map_unlock <= 1'b1;
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'h40));
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'h00));
      chk(pin_map_lock, 1'b1);
      pulse_in(0);
      rchk(OSCDC_ADDR_CTRL, 16'h0048);
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'h80));
      rchk(OSCDC_ADDR_CTRL, 16'h00C0);
      wr(OSCDC_ADDR_CTRL, cw(3'b101, 8'h01));
      rchk(OSCDC_ADDR_CTRL, 16'h00C0);
      wr(OSCDC_ADDR_DIV, 16'h0100);
      cyc(15);
      chk(sys_source, 3'b000);
      chk(pll_on, 1'b1);
      $display("test lock bits done");
      rst('{2'b01, 2'b11, 3'b000, 1'b0});
      chk(failsafe_clock_monitor, 1'b0);
      chk(sys_source, 3'b000);
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'hC0));
      wr(OSCDC_ADDR_CTRL, cw(3'b101, 8'h81));
      wait_sw();
      chk(sys_source, 3'b101);
      chk(pin_map_lock, 1'b0);
      $display("test monitor disabled done");
      rst('{2'b10, 2'b01, 3'b011, 1'b0});
      chk(sys_source, 3'b011);
      rchk(OSCDC_ADDR_CTRL, 16'h3300);
      wr(OSCDC_ADDR_CTRL, cw(3'b000, 8'h01));
      cyc(20);
      chk(sys_source, 3'b011);
      $display("test switching disabled done");
      finish_test();
   end
endmodule
`default_nettype wire
